// >>> inc/stp_params.svh
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH
// Register byte offsets
`define STP_A_STEP   8'h00
`define STP_A_RUNCUR 8'h04
`define STP_A_STPCUR 8'h08
`define STP_A_RSEL   8'h0c
`define STP_A_COMACC 8'h10
`define STP_A_COMDEC 8'h14
`define STP_A_TIDX   8'h18
`define STP_A_TACC   8'h1c
`define STP_A_TDEC   8'h20
`define STP_A_TRAVEL 8'h24
`define STP_A_SSPD   8'h28
`define STP_A_RSPD   8'h2c
`define STP_A_CMD    8'h30
`define STP_A_STAT   8'h34
`define STP_A_SPEED  8'h38
`define STP_A_REMAIN 8'h3c
// Command fields
`define STP_CMD_GO   0
`define STP_CMD_LINK 1
`define STP_CMD_NO_L 8
// Reset values and ranges
`define STP_STEP_RST 4'h0
`define STP_RUN_RST  7'h64
`define STP_RUN_MIN  32'h5
`define STP_RUN_MAX  32'h64
`define STP_STP_RST  6'h32
`define STP_STP_MAX  32'h32
`define STP_RATE_RST 20'h07530
`define STP_RATE_MIN 32'h1
`define STP_RATE_MAX 32'hf4240
`define STP_SSPD_RST 19'h001f4
`define STP_RSPD_RST 19'h003e8
`define STP_SPD_MAX  32'h7a120
`define STP_PCT_FULL 32'h64
// Timing: clock period in ns, clock rate in Hz
`define STP_CLK_NS   5
`define STP_SYS_HZ   (1000000000 / `STP_CLK_NS)
// Braking distance divisor: 2 * 1e9 ns per s
`define STP_BRK_DIV  58'd2000000000
`endif

// >>> inc/stp_pkg.sv
package stp_pkg;
    typedef enum logic [1:0] {
        STP_IDLE   = 2'b00,
        STP_ACCEL  = 2'b01,
        STP_CRUISE = 2'b10,
        STP_DECEL  = 2'b11
    } stp_state_t;
    typedef struct packed {
        logic [19:0] acc;
        logic        tick;
    } stp_ramp_t;
    typedef struct packed {
        logic [27:0] acc;
        logic        pulse;
    } stp_gen_t;
endpackage

// >>> design/stp_ramp_tick.sv
`timescale 1ns/100ps
`include "stp_params.svh"
// One tick per Hz of speed change; rate is ns per Hz
module stp_ramp_tick (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [19:0] rate,
    output logic             tick
);
    stp_pkg::stp_ramp_t s, next_s;
    logic [20:0] sum;

    // Accumulate elapsed ns against the rate
    always_comb
    begin
        next_s = s;
        sum = {1'b0, s.acc} + 21'(`STP_CLK_NS);
        next_s.tick = 1'b0;
        if (!run)
        begin
            next_s.acc = 20'h0;
        end
        else if (sum >= {1'b0, rate})
        begin
            next_s.tick = 1'b1;
            next_s.acc = 20'(sum - {1'b0, rate});
        end
        else
        begin
            next_s.acc = sum[19:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;
endmodule // stp_ramp_tick

// >>> design/stp_pulse_gen.sv
`timescale 1ns/100ps
`include "stp_params.svh"
// Phase accumulator: spd pulses per second
module stp_pulse_gen (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [18:0] spd,
    output logic             pulse
);
    stp_pkg::stp_gen_t s, next_s;
    logic [28:0] sum;

    // Wrap at the clock rate and emit one pulse
    always_comb
    begin
        next_s = s;
        sum = {1'b0, s.acc} + {10'h0, spd};
        next_s.pulse = 1'b0;
        if (!run)
        begin
            next_s.acc = 28'h0;
        end
        else if (sum >= 29'(`STP_SYS_HZ))
        begin
            next_s.pulse = 1'b1;
            next_s.acc = 28'(sum - 29'(`STP_SYS_HZ));
        end
        else
        begin
            next_s.acc = sum[27:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign pulse = s.pulse;
endmodule // stp_pulse_gen

// >>> design/stp_motion.sv
// Function
// - Step angle setting 0..15, reset 0
// - Setting maps to division 1 to 250
// - Run current 5..100 percent, default 100
// - Cut current to standstill level when stopped
// - Standstill current 0..50 percent, default 50
// - Standstill level ignores run current setting
// - Rates in ms/kHz, 0.001..1000, default 30
// - Rate source: 0 common, 1 per data
// - Per data uses executing data number rates
// - Linked moves keep first data's rates
// - Start speed, ramp, cruise, decelerate, stop
// - 63 per-data acceleration and deceleration rates
`timescale 1ns/100ps
`include "stp_params.svh"
module stp_motion #(
    parameter int RATED_MA = 1000
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    output logic             step_pulse,
    output logic             step_dir,
    output logic      [6:0]  cur_pct,
    output logic      [15:0] cur_ma,
    output logic      [8:0]  div_x2,
    output logic             moving
);
    typedef struct packed {
        logic [3:0]        step_sel;
        logic [6:0]        run_pct;
        logic [5:0]        stop_pct;
        logic              rate_sel;
        logic [19:0]       com_acc;
        logic [19:0]       com_dec;
        logic [5:0]        tab_idx;
        logic [62:0][19:0] acc_tab;
        logic [62:0][19:0] dec_tab;
        logic [23:0]       travel;
        logic [18:0]       start_spd;
        logic [18:0]       run_spd;
        logic [5:0]        rate_no;
        logic [5:0]        exec_no;
        stp_pkg::stp_state_t fsm;
        logic [18:0]       speed;
        logic [23:0]       remain;
        logic              dir;
        logic [31:0]       rdata;
        logic              pulse;
        logic [6:0]        cur_pct;
        logic [15:0]       cur_ma;
        logic [8:0]        div_x2;
        logic              moving;
    } stp_top_t;

    stp_top_t s, next_s;
    logic        ramp_tick;
    logic        gen_pulse;
    logic [19:0] acc_now;
    logic [19:0] dec_now;
    logic [37:0] dsq;
    logic [57:0] brake;
    logic [6:0]  pct_now;
    logic        go;
    logic        ramp_run;
    logic [19:0] ramp_rate;
    logic        gen_run;
    logic        cmd_link;
    logic [5:0]  cmd_no;

    // Clamp a written value into its legal range
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        if (v < lo)
            return lo;
        if (v > hi)
            return hi;
        return v;
    endfunction

    // Pick per-data rate or common rate
    function automatic logic [19:0] pick_rate(input logic sel,
                                              input logic [5:0] no,
                                              input logic [62:0][19:0] tab,
                                              input logic [19:0] com);
        if (sel && no != 6'h0)
            return tab[no - 6'h1];
        return com;
    endfunction

    // Rate value into its legal range
    function automatic logic [19:0] clamp_rate(input logic [31:0] v);
        return 20'(clamp(v, `STP_RATE_MIN, `STP_RATE_MAX));
    endfunction

    // A table index of zero selects no entry
    function automatic logic tab_ok(input logic [5:0] idx);
        return idx != 6'h0;
    endfunction

    // Division times two for each step angle setting
    function automatic logic [8:0] div_of(input logic [3:0] sel);
        unique case (sel)
            4'h0: return 9'h002;
            4'h1: return 9'h004;
            4'h2: return 9'h005;
            4'h3: return 9'h008;
            4'h4: return 9'h00a;
            4'h5: return 9'h010;
            4'h6: return 9'h014;
            4'h7: return 9'h028;
            4'h8: return 9'h032;
            4'h9: return 9'h050;
            4'ha: return 9'h064;
            4'hb: return 9'h0a0;
            4'hc: return 9'h0c8;
            4'hd: return 9'h0fa;
            4'he: return 9'h190;
            4'hf: return 9'h1f4;
        endcase
    endfunction

    // Rate selection for the move in progress
    always_comb
    begin
        acc_now = pick_rate(s.rate_sel, s.rate_no, s.acc_tab, s.com_acc);
        dec_now = pick_rate(s.rate_sel, s.rate_no, s.dec_tab, s.com_dec);
    end

    // Braking distance (v^2 - vs^2) * r / 2e9
    always_comb
    begin
        dsq = (38'(s.speed) * 38'(s.speed)) - (38'(s.start_spd) * 38'(s.start_spd));
        brake = (58'(dsq) * 58'(dec_now)) / `STP_BRK_DIV;
    end

    // Run and rate controls for the ramp and pulse units
    always_comb
    begin
        ramp_run  = (s.fsm == stp_pkg::STP_ACCEL) || (s.fsm == stp_pkg::STP_DECEL);
        ramp_rate = (s.fsm == stp_pkg::STP_DECEL) ? dec_now : acc_now;
        gen_run   = (s.fsm != stp_pkg::STP_IDLE);
    end

    // Command word fields
    assign cmd_link = wr_data[`STP_CMD_LINK];
    assign cmd_no   = wr_data[`STP_CMD_NO_L +: 6];

    stp_ramp_tick u_ramp (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (ramp_run),
        .rate    (ramp_rate),
        .tick    (ramp_tick)
    );

    stp_pulse_gen u_gen (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (gen_run),
        .spd     (s.speed),
        .pulse   (gen_pulse)
    );

    // Register writes, reads and the motion profile
    always_comb
    begin
        next_s = s;
        next_s.pulse = 1'b0;
        go = 1'b0;
        // Register writes with range clamping
        if (wr_en)
        begin
            unique case (addr)
                `STP_A_STEP:
                    next_s.step_sel = wr_data[3:0];
                `STP_A_RUNCUR:
                    next_s.run_pct = 7'(clamp(wr_data, `STP_RUN_MIN, `STP_RUN_MAX));
                `STP_A_STPCUR:
                    next_s.stop_pct = 6'(clamp(wr_data, 32'h0, `STP_STP_MAX));
                `STP_A_RSEL:
                    next_s.rate_sel = wr_data[0];
                `STP_A_COMACC:
                    next_s.com_acc = clamp_rate(wr_data);
                `STP_A_COMDEC:
                    next_s.com_dec = clamp_rate(wr_data);
                `STP_A_TIDX:
                    next_s.tab_idx = wr_data[5:0];
                `STP_A_TACC:
                    if (tab_ok(s.tab_idx))
                        next_s.acc_tab[s.tab_idx - 6'h1] = clamp_rate(wr_data);
                `STP_A_TDEC:
                    if (tab_ok(s.tab_idx))
                        next_s.dec_tab[s.tab_idx - 6'h1] = clamp_rate(wr_data);
                `STP_A_TRAVEL:
                    next_s.travel = wr_data[23:0];
                `STP_A_SSPD:
                    next_s.start_spd = 19'(clamp(wr_data, 32'h1, `STP_SPD_MAX));
                `STP_A_RSPD:
                    next_s.run_spd = 19'(clamp(wr_data, 32'h1, `STP_SPD_MAX));
                `STP_A_CMD:
                    go = wr_data[`STP_CMD_GO];
                default: ;
            endcase
        end
        // Read data, one cycle after the strobe
        next_s.rdata = 32'h0;
        if (rd_en)
        begin
            unique case (addr)
                `STP_A_STEP:   next_s.rdata = {28'h0, s.step_sel};
                `STP_A_RUNCUR: next_s.rdata = {25'h0, s.run_pct};
                `STP_A_STPCUR: next_s.rdata = {26'h0, s.stop_pct};
                `STP_A_RSEL:   next_s.rdata = {31'h0, s.rate_sel};
                `STP_A_COMACC: next_s.rdata = {12'h0, s.com_acc};
                `STP_A_COMDEC: next_s.rdata = {12'h0, s.com_dec};
                `STP_A_TIDX:   next_s.rdata = {26'h0, s.tab_idx};
                `STP_A_TACC:
                    if (tab_ok(s.tab_idx))
                        next_s.rdata = {12'h0, s.acc_tab[s.tab_idx - 6'h1]};
                `STP_A_TDEC:
                    if (tab_ok(s.tab_idx))
                        next_s.rdata = {12'h0, s.dec_tab[s.tab_idx - 6'h1]};
                `STP_A_TRAVEL: next_s.rdata = {{8{s.travel[23]}}, s.travel};
                `STP_A_SSPD:   next_s.rdata = {13'h0, s.start_spd};
                `STP_A_RSPD:   next_s.rdata = {13'h0, s.run_spd};
                `STP_A_CMD:    next_s.rdata = {18'h0, s.exec_no, s.rate_no, 2'h0};
                `STP_A_STAT:   next_s.rdata = {29'h0, s.dir, s.fsm};
                `STP_A_SPEED:  next_s.rdata = {13'h0, s.speed};
                `STP_A_REMAIN: next_s.rdata = {8'h0, s.remain};
                default:       next_s.rdata = 32'h0;
            endcase
        end
        // Move profile state machine
        unique case (s.fsm)
            stp_pkg::STP_IDLE:
                if (go && s.travel != 24'h0)
                begin
                    next_s.exec_no = cmd_no;
                    if (!cmd_link)
                        next_s.rate_no = cmd_no;
                    next_s.dir = s.travel[23];
                    next_s.remain = s.travel[23] ? -s.travel : s.travel;
                    next_s.speed = s.start_spd;
                    next_s.fsm = (s.start_spd >= s.run_spd) ?
                                 stp_pkg::STP_CRUISE : stp_pkg::STP_ACCEL;
                end
            stp_pkg::STP_ACCEL:
                if (58'(s.remain) <= brake)
                    next_s.fsm = stp_pkg::STP_DECEL;
                else if (ramp_tick)
                begin
                    next_s.speed = s.speed + 19'h1;
                    if (s.speed + 19'h1 >= s.run_spd)
                        next_s.fsm = stp_pkg::STP_CRUISE;
                end
            stp_pkg::STP_CRUISE:
                if (58'(s.remain) <= brake)
                    next_s.fsm = stp_pkg::STP_DECEL;
            stp_pkg::STP_DECEL:
                if (ramp_tick && s.speed > s.start_spd)
                    next_s.speed = s.speed - 19'h1;
        endcase
        // Step output and distance count
        if (s.fsm != stp_pkg::STP_IDLE && gen_pulse)
        begin
            next_s.pulse = 1'b1;
            next_s.remain = s.remain - 24'h1;
            if (s.remain == 24'h1)
            begin
                next_s.fsm = stp_pkg::STP_IDLE;
                next_s.speed = 19'h0;
            end
        end
        pct_now = (next_s.fsm == stp_pkg::STP_IDLE) ? {1'b0, s.stop_pct} : s.run_pct;
        next_s.cur_pct = pct_now;
        next_s.cur_ma = 16'((32'(pct_now) * RATED_MA) / `STP_PCT_FULL);
        next_s.div_x2 = div_of(s.step_sel);
        // Move flag registered with the state
        next_s.moving = (next_s.fsm != stp_pkg::STP_IDLE);
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= '0;
            // Settings to their defaults
            s.step_sel <= `STP_STEP_RST;
            s.run_pct <= `STP_RUN_RST;
            s.stop_pct <= `STP_STP_RST;
            s.rate_sel <= 1'b0;
            s.com_acc <= `STP_RATE_RST;
            s.com_dec <= `STP_RATE_RST;
            s.acc_tab <= {63{`STP_RATE_RST}};
            s.dec_tab <= {63{`STP_RATE_RST}};
            s.start_spd <= `STP_SSPD_RST;
            s.run_spd <= `STP_RSPD_RST;
            // Outputs consistent with standstill
            s.cur_pct <= {1'b0, `STP_STP_RST};
            s.cur_ma <= 16'((32'(`STP_STP_RST) * RATED_MA) / `STP_PCT_FULL);
            s.div_x2 <= 9'h002;
            // Motion at rest
            s.fsm <= stp_pkg::STP_IDLE;
            s.moving <= 1'b0;
        end
        else
            s <= next_s;
    end

    // Outputs straight from the state register
    assign rd_data    = s.rdata;
    assign step_pulse = s.pulse;
    assign step_dir   = s.dir;
    assign cur_pct    = s.cur_pct;
    assign cur_ma     = s.cur_ma;
    assign div_x2     = s.div_x2;
    assign moving     = s.moving;
endmodule // stp_motion

// >>> test/stp_motion_sva.sv
`timescale 1ns/100ps
module stp_motion_chk #(
    parameter int RATED_MA = 1000
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    input wire logic        step_pulse,
    input wire logic        step_dir,
    input wire logic [6:0]  cur_pct,
    input wire logic [15:0] cur_ma,
    input wire logic [8:0]  div_x2,
    input wire logic        moving
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Read data only in the answer cycle
    property p_rd_idle;
        !$past(rd_en) |-> rd_data == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
    property p_rd_unmapped;
        $past(rd_en) && ($past(addr) > 8'h3c) |-> rd_data == 32'h0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_div;
        div_x2 inside {9'h002, 9'h004, 9'h005, 9'h008, 9'h00a, 9'h010, 9'h014, 9'h028,
                       9'h032, 9'h050, 9'h064, 9'h0a0, 9'h0c8, 9'h0fa, 9'h190, 9'h1f4};
    endproperty
    a_div: assert property (p_div) else $error("division not in table");
    property p_idle_cur;
        !moving |-> cur_pct <= 7'h32;
    endproperty
    a_idle_cur: assert property (p_idle_cur) else $error("idle current above limit");
    property p_run_cur;
        moving |-> cur_pct >= 7'h05;
    endproperty
    a_run_cur: assert property (p_run_cur) else $error("run current below limit");
    property p_cur_ma;
        cur_ma == 16'(32'(cur_pct) * RATED_MA / 32'h64);
    endproperty
    a_cur_ma: assert property (p_cur_ma) else $error("current in mA mismatch");
    // Step pulses are single cycles inside a move
    property p_pulse_one;
        step_pulse |=> !step_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("step pulse too long");
    property p_pulse_move;
        step_pulse |-> $past(moving);
    endproperty
    a_pulse_move: assert property (p_pulse_move) else $error("step outside move");
    property p_dir;
        moving && $past(moving) |-> $stable(step_dir);
    endproperty
    a_dir: assert property (p_dir) else $error("direction changed in move");
endmodule // stp_motion_chk

bind stp_motion stp_motion_chk #(.RATED_MA(RATED_MA)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .step_pulse(step_pulse), .step_dir(step_dir),
    .cur_pct(cur_pct), .cur_ma(cur_ma), .div_x2(div_x2), .moving(moving)
);

// >>> test/stp_motor_model.sv
`timescale 1ns/100ps
module stp_motor_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic step_pulse,
    input  wire logic step_dir,
    output int        position
);
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            position <= 0;
        else if (step_pulse)
            position <= step_dir ? position - 1 : position + 1;
    end
endmodule // stp_motor_model

// >>> test/stp_motion_test.sv
`timescale 1ns/100ps
`include "stp_params.svh"
module stp_motion_test;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en   = 1'b0;
    logic        rd_en   = 1'b0;
    logic [31:0] rd_data;
    logic        step_pulse;
    logic        step_dir;
    logic [6:0]  cur_pct;
    logic [15:0] cur_ma;
    logic [8:0]  div_x2;
    logic        moving;
    logic [31:0] v;
    logic [31:0] w;
    int          position;
    int          err_total = 0;
    int          checks    = 0;
    logic [8:0]  div_tab [16] = '{9'h002, 9'h004, 9'h005, 9'h008, 9'h00a, 9'h010, 9'h014, 9'h028,
                                  9'h032, 9'h050, 9'h064, 9'h0a0, 9'h0c8, 9'h0fa, 9'h190, 9'h1f4};

    always #2.5 sys_clk = ~sys_clk;

    stp_motion dut (
        .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .step_pulse(step_pulse), .step_dir(step_dir),
        .cur_pct(cur_pct), .cur_ma(cur_ma), .div_x2(div_x2), .moving(moving)
    );
    stp_motor_model u_motor (
        .sys_clk(sys_clk), .rst(rst), .step_pulse(step_pulse), .step_dir(step_dir),
        .position(position)
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        rd(a, v);
        chk(v & mask, exp);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (moving !== 1'b0 && n < 6000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        // Let the model count the last step
        @(posedge sys_clk);
        #1 chk({31'h0, moving}, 32'h0);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog at 30000 cycles, several times the expected run
    initial
    begin
        #150000;
        err_total++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1 chk({23'h0, div_x2}, 32'h2);
        chk({25'h0, cur_pct}, 32'h32);
        chk_reg(`STP_A_STEP, 32'hf, 32'h0);
        chk_reg(`STP_A_RUNCUR, 32'h7f, 32'h64);
        chk_reg(`STP_A_COMACC, 32'hfffff, 32'h7530);
        chk_reg(`STP_A_RSEL, 32'h1, 32'h0);
        chk_reg(8'h40, 32'hffffffff, 32'h0);
        for (int s = 0; s < 16; s++)
        begin
            wr(`STP_A_STEP, 32'(s));
            repeat (2) @(posedge sys_clk);
            #1 chk({23'h0, div_x2}, {23'h0, div_tab[s]});
        end
        // Out-of-range settings are clamped
        wr(`STP_A_RUNCUR, 32'h2);
        chk_reg(`STP_A_RUNCUR, 32'h7f, 32'h5);
        wr(`STP_A_RUNCUR, 32'hc8);
        chk_reg(`STP_A_RUNCUR, 32'h7f, 32'h64);
        wr(`STP_A_STPCUR, 32'h3c);
        chk_reg(`STP_A_STPCUR, 32'h3f, 32'h32);
        wr(`STP_A_COMACC, 32'h0);
        chk_reg(`STP_A_COMACC, 32'hfffff, 32'h1);
        wr(`STP_A_COMDEC, 32'h200000);
        chk_reg(`STP_A_COMDEC, 32'hfffff, 32'hf4240);
        // Per-data rates, ramp from start speed, three steps forward
        wr(`STP_A_RUNCUR, 32'h14);
        wr(`STP_A_STPCUR, 32'h1e);
        wr(`STP_A_SSPD, 32'h61a80);
        wr(`STP_A_RSPD, 32'h61e68);
        wr(`STP_A_RSEL, 32'h1);
        wr(`STP_A_TIDX, 32'h5);
        wr(`STP_A_TACC, 32'h1);
        wr(`STP_A_TDEC, 32'h1);
        chk_reg(`STP_A_TACC, 32'hfffff, 32'h1);
        wr(`STP_A_TRAVEL, 32'h3);
        wr(`STP_A_CMD, 32'h0501);
        chk_reg(`STP_A_STAT, 32'h3, 32'h1);
        chk({25'h0, cur_pct}, 32'h14);
        chk_reg(`STP_A_CMD, 32'h3ffc, 32'h0514);
        wait_idle();
        chk(32'(position), 32'h3);
        chk({25'h0, cur_pct}, 32'h1e);
        wr(`STP_A_RUNCUR, 32'h50);
        repeat (2) @(posedge sys_clk);
        #1 chk({25'h0, cur_pct}, 32'h1e);
        chk({16'h0, cur_ma}, 32'h12c);
        // Linked move keeps the first data's rates, four steps back
        // Data 5 now ramps at 10 ns/Hz, data 7 keeps the slow default
        wr(`STP_A_TACC, 32'ha);
        wr(`STP_A_TRAVEL, 32'hfffffc);
        wr(`STP_A_CMD, 32'h0703);
        chk_reg(`STP_A_CMD, 32'h3ffc, 32'h0714);
        chk({25'h0, cur_pct}, 32'h50);
        chk({31'h0, step_dir}, 32'h1);
        // One Hz every second clock while ramping up
        rd(`STP_A_SPEED, v);
        rd(`STP_A_SPEED, w);
        chk(w - v, 32'h1);
        wait_idle();
        chk(32'(position), 32'hffffffff);
        report_and_stop();
    end
endmodule // stp_motion_test
